// file: rtl/bmp_pkg.sv
// Purpose: Shared constants and types for the single-wire battery monitor register port
// Assumes: 20 MHz system clock
// Notes:   Times are in microseconds; cycle counts derive from them
package bmp_pkg;

    localparam int CLK_MHZ              = 20;
    // Line timing, microseconds
    localparam int BIT_THRESHOLD_US     = 100;
    localparam int BREAK_US             = 190;
    localparam int BREAK_RECOVERY_US    = 40;
    localparam int DEVICE_START_LOW_US  = 40;
    localparam int DEVICE_DATA_HOLD_US  = 100;
    localparam int DEVICE_BIT_CYCLE_US  = 200;
    localparam int TURNAROUND_US        = 200;

    localparam int CNT_W = 13;
    localparam logic [CNT_W-1:0] BIT_THRESH_CYC = CNT_W'(BIT_THRESHOLD_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] BREAK_CYC      = CNT_W'(BREAK_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] RECOVERY_CYC   = CNT_W'(BREAK_RECOVERY_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] DEV_LOW_CYC    = CNT_W'(DEVICE_START_LOW_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] DEV_HOLD_CYC   = CNT_W'(DEVICE_DATA_HOLD_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] DEV_CYCLE_CYC  = CNT_W'(DEVICE_BIT_CYCLE_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] TURN_CYC       = CNT_W'(TURNAROUND_US * CLK_MHZ);

    // Register addresses
    localparam logic [6:0] ADDR_RAM_TOP   = 7'h1f;
    localparam logic [6:0] ADDR_FLASH_TOP = 7'h5f;
    localparam logic [6:0] ADDR_FLASH_CMD = 7'h62;
    localparam logic [6:0] ADDR_CLEAR     = 7'h63;
    localparam logic [6:0] ADDR_PROG_DATA = 7'h6f;
    localparam logic [6:0] ADDR_PROG_ADDR = 7'h70;
    localparam logic [6:0] ADDR_VOLT_LOW  = 7'h71;
    localparam logic [6:0] ADDR_VOLT_HIGH = 7'h72;
    localparam logic [6:0] ADDR_ID        = 7'h7f;

    localparam int PAGE_BYTES  = 32;
    localparam int FLASH_BYTES = 96;
    localparam int CLEAR_W     = 5;
    localparam int CLEAR_DISCHARGE      = 0;
    localparam int CLEAR_CHARGE         = 1;
    localparam int CLEAR_SELF_DISCHARGE = 2;
    localparam int CLEAR_DISCHARGE_TIME = 3;
    localparam int CLEAR_CHARGE_TIME    = 4;
    localparam int OFFSET_LSB  = 3;
    localparam logic [7:0] ERASED = 8'hff;

    typedef enum logic [7:0] {
        FC_PROGRAM      = 8'h0f,
        FC_ERASE0       = 8'h40,
        FC_ERASE1       = 8'h41,
        FC_ERASE2       = 8'h42,
        FC_RAM_TO_FLASH = 8'h45,
        FC_FLASH_TO_RAM = 8'h48,
        FC_POWER_DOWN   = 8'hf6
    } bmp_flash_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_MEASURE = 3'b001,
        ST_BREAK   = 3'b010,
        ST_RECOVER = 3'b011,
        ST_TURN    = 3'b100,
        ST_TX      = 3'b101
    } bmp_state_t;

    typedef struct packed {
        logic       write;
        logic [6:0] addr;
    } bmp_cmd_t;

endpackage

// file: rtl/bmp_port.sv
// Purpose: Single-wire return-to-one register port with flash command engine
// Assumes: line_in synchronous to clk; external pull-up; line_out/line_oe open drain
// Notes:   Flash and RAM arrays hold no reset; RAM reloads from flash page 0 after reset
`timescale 1ns/100ps

module bmp_port #(
    parameter logic [7:0] ID_CODE = 8'h5a  // Arbitrary identification value
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        line_in,
    output logic             line_out,
    output logic             line_oe,
    input  wire logic [10:0] battery_voltage,
    input  wire logic [4:0]  voltage_offset,
    output logic [4:0]       counter_clear,
    output logic             power_down
);

    bmp_pkg::bmp_state_t             st;
    logic [bmp_pkg::CNT_W-1:0]       cnt;
    logic [7:0]                      shreg;
    logic [2:0]                      bitcnt;
    logic                            data_phase;
    bmp_pkg::bmp_cmd_t               cmd;
    logic [7:0]                      tx_data;
    logic [2:0]                      tx_bit;
    logic [7:0]                      flash_program_data_reg;
    logic [7:0]                      flash_program_address_reg;
    logic [7:0]                      battery_voltage_low_reg;
    logic [7:0]                      battery_voltage_high_reg;
    logic [bmp_pkg::CLEAR_W-1:0]     counter_clear_reg;
    logic                            por_load;
    logic [7:0]                      ram   [bmp_pkg::PAGE_BYTES];
    logic [7:0]                      flash [bmp_pkg::FLASH_BYTES];

    logic                            rise;
    logic                            rx_bit;
    logic [7:0]                      rx_byte;
    logic                            byte_done;
    logic                            wr_en;
    logic                            flash_cmd_wr;
    logic [6:0]                      prog_idx;
    logic                            next_oe;
    logic [7:0]                      rd_data;

    assign rise      = (st == bmp_pkg::ST_MEASURE) && line_in;
    assign rx_bit    = cnt < bmp_pkg::BIT_THRESH_CYC;
    assign rx_byte   = {rx_bit, shreg[7:1]};
    assign byte_done = rise && (bitcnt == 3'd7);
    assign wr_en     = byte_done && data_phase;
    assign flash_cmd_wr = wr_en && (cmd.addr == bmp_pkg::ADDR_FLASH_CMD);
    assign prog_idx  = flash_program_address_reg[6:0];

    // Read mux; write-only and unmapped addresses read zero
    always_comb begin
        rd_data = 8'h00;
        if (cmd.addr <= bmp_pkg::ADDR_RAM_TOP) begin
            rd_data = ram[cmd.addr[4:0]];
        end else if (cmd.addr <= bmp_pkg::ADDR_FLASH_TOP) begin
            rd_data = flash[cmd.addr];
        end else begin
            unique case (cmd.addr)
                bmp_pkg::ADDR_CLEAR:     rd_data = {3'h0, counter_clear_reg};
                bmp_pkg::ADDR_PROG_DATA: rd_data = flash_program_data_reg;
                bmp_pkg::ADDR_PROG_ADDR: rd_data = flash_program_address_reg;
                bmp_pkg::ADDR_VOLT_LOW:  rd_data = battery_voltage_low_reg;
                bmp_pkg::ADDR_VOLT_HIGH: rd_data = battery_voltage_high_reg;
                bmp_pkg::ADDR_ID:   rd_data = ID_CODE;
                default:            rd_data = 8'h00;
            endcase
        end
    end

    // Line state machine: receive, break, turnaround, transmit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st         <= bmp_pkg::ST_RECOVER;
            cnt        <= '0;
            shreg      <= 8'h00;
            bitcnt     <= 3'd0;
            data_phase <= 1'b0;
            cmd        <= '0;
            tx_data    <= 8'h00;
            tx_bit     <= 3'd0;
        end else begin
            unique case (st)
                bmp_pkg::ST_IDLE: begin
                    cnt <= '0;
                    if (!line_in) begin
                        st <= bmp_pkg::ST_MEASURE;
                    end
                end
                bmp_pkg::ST_MEASURE: begin
                    if (line_in) begin
                        shreg  <= rx_byte;
                        bitcnt <= bitcnt + 3'd1;
                        cnt    <= '0;
                        st     <= bmp_pkg::ST_IDLE;
                        if (byte_done && !data_phase) begin
                            cmd <= rx_byte;
                            if (rx_byte[7]) begin
                                data_phase <= 1'b1;
                            end else begin
                                tx_data <= 8'h00;
                                st      <= bmp_pkg::ST_TURN;
                            end
                        end else if (byte_done) begin
                            data_phase <= 1'b0;
                        end
                    end else if (cnt == bmp_pkg::BREAK_CYC - 1'b1) begin
                        st <= bmp_pkg::ST_BREAK;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                bmp_pkg::ST_BREAK: begin
                    bitcnt     <= 3'd0;
                    data_phase <= 1'b0;
                    cnt        <= '0;
                    if (line_in) begin
                        st <= bmp_pkg::ST_RECOVER;
                    end
                end
                bmp_pkg::ST_RECOVER: begin
                    // Line must stay high for the whole recovery
                    if (!line_in) begin
                        cnt <= '0;
                    end else if (cnt == bmp_pkg::RECOVERY_CYC - 1'b1) begin
                        cnt <= '0;
                        st  <= bmp_pkg::ST_IDLE;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                bmp_pkg::ST_TURN: begin
                    tx_data <= rd_data;
                    tx_bit  <= 3'd0;
                    if (cnt == bmp_pkg::TURN_CYC - 1'b1) begin
                        cnt <= '0;
                        st  <= bmp_pkg::ST_TX;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                bmp_pkg::ST_TX: begin
                    if (cnt == bmp_pkg::DEV_CYCLE_CYC - 1'b1) begin
                        cnt     <= '0;
                        tx_data <= {1'b0, tx_data[7:1]};
                        tx_bit  <= tx_bit + 3'd1;
                        if (tx_bit == 3'd7) begin
                            bitcnt <= 3'd0;
                            st     <= bmp_pkg::ST_IDLE;
                        end
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                default: st <= bmp_pkg::ST_IDLE;
            endcase
        end
    end

    // Low for start time; a zero stays low until hold time
    always_comb begin
        next_oe = 1'b0;
        if (st == bmp_pkg::ST_TX) begin
            next_oe = (cnt < bmp_pkg::DEV_LOW_CYC)
                   || (!tx_data[0] && (cnt < bmp_pkg::DEV_HOLD_CYC));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_oe  <= 1'b0;
            line_out <= 1'b0;
        end else begin
            line_oe  <= next_oe;
            line_out <= 1'b0;
        end
    end

    // Host-written registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flash_program_data_reg    <= 8'h00;
            flash_program_address_reg <= 8'h00;
        end else if (wr_en) begin
            if (cmd.addr == bmp_pkg::ADDR_PROG_DATA) begin
                flash_program_data_reg <= rx_byte;
            end
            if (cmd.addr == bmp_pkg::ADDR_PROG_ADDR) begin
                flash_program_address_reg <= rx_byte;
            end
        end
    end

    // Clear bits live one cycle; counter_clear follows counter_clear_reg
    // one cycle later
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            counter_clear_reg <= '0;
            counter_clear     <= '0;
        end else begin
            counter_clear <= counter_clear_reg;
            if (wr_en && cmd.addr == bmp_pkg::ADDR_CLEAR) begin
                counter_clear_reg <= rx_byte[bmp_pkg::CLEAR_W-1:0];
            end else begin
                counter_clear_reg <= '0;
            end
        end
    end

    // Voltage captured while no read is in flight, so a byte is coherent
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            battery_voltage_low_reg  <= 8'h00;
            battery_voltage_high_reg <= 8'h00;
        end else if (st == bmp_pkg::ST_IDLE) begin
            battery_voltage_low_reg  <= battery_voltage[7:0];
            battery_voltage_high_reg <= {voltage_offset, battery_voltage[10:8]};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_down <= 1'b0;
            por_load   <= 1'b1;
        end else begin
            por_load <= 1'b0;
            if (flash_cmd_wr && rx_byte == bmp_pkg::FC_POWER_DOWN) begin
                power_down <= 1'b1;
            end
        end
    end

    // Nonvolatile: no reset; program only clears bits
    always_ff @(posedge clk) begin
        if (flash_cmd_wr) begin
            unique case (rx_byte)
                bmp_pkg::FC_PROGRAM: begin
                    if (prog_idx < 7'(bmp_pkg::FLASH_BYTES)) begin
                        flash[prog_idx] <= flash[prog_idx] & flash_program_data_reg;
                    end
                end
                bmp_pkg::FC_ERASE0, bmp_pkg::FC_ERASE1, bmp_pkg::FC_ERASE2: begin
                    for (int i = 0; i < bmp_pkg::PAGE_BYTES; i++) begin
                        flash[rx_byte[1:0]*bmp_pkg::PAGE_BYTES + i] <= bmp_pkg::ERASED;
                    end
                end
                bmp_pkg::FC_RAM_TO_FLASH: begin
                    for (int i = 0; i < bmp_pkg::PAGE_BYTES; i++) begin
                        flash[i] <= flash[i] & ram[i];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (por_load || (flash_cmd_wr && rx_byte == bmp_pkg::FC_FLASH_TO_RAM)) begin
            for (int i = 0; i < bmp_pkg::PAGE_BYTES; i++) begin
                ram[i] <= flash[i];
            end
        end else if (wr_en && cmd.addr <= bmp_pkg::ADDR_RAM_TOP) begin
            ram[cmd.addr[4:0]] <= rx_byte;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_break_detect: assert property (
        (st == bmp_pkg::ST_MEASURE && !line_in && cnt == bmp_pkg::BREAK_CYC - 1'b1)
        |=> st == bmp_pkg::ST_BREAK)
        else $error("break not detected");
    a_idle_release: assert property (
        (st == bmp_pkg::ST_IDLE) |=> !line_oe)
        else $error("line driven while idle");
    a_start_low: assert property (
        (st == bmp_pkg::ST_TX && cnt == '0) |=> line_oe)
        else $error("no start low on device bit");
    a_one_release: assert property (
        (st == bmp_pkg::ST_TX && tx_data[0] && cnt == bmp_pkg::DEV_LOW_CYC) |=> !line_oe)
        else $error("one bit held low too long");
    a_clear_pulse: assert property (
        (counter_clear_reg != '0) |=> counter_clear_reg == '0
        && counter_clear == $past(counter_clear_reg))
        else $error("clear bit not self-clearing");
    a_power_down: assert property (
        (flash_cmd_wr && rx_byte == bmp_pkg::FC_POWER_DOWN) |=> power_down)
        else $error("power down not taken");
    a_read_answer: assert property (
        (byte_done && !data_phase && !rx_byte[7]) |=> st == bmp_pkg::ST_TURN)
        else $error("read command not answered");
    a_erase_page: assert property (
        (flash_cmd_wr && rx_byte == bmp_pkg::FC_ERASE1) |=> flash[32] == bmp_pkg::ERASED)
        else $error("page 1 not erased");
    a_xfer_and: assert property (
        (flash_cmd_wr && rx_byte == bmp_pkg::FC_RAM_TO_FLASH)
        |=> flash[0] == ($past(flash[0]) & $past(ram[0])))
        else $error("transfer did not AND");

    c_read: cover property (st == bmp_pkg::ST_TURN ##1 st == bmp_pkg::ST_TX);
    c_write: cover property (wr_en);
    c_break: cover property (st == bmp_pkg::ST_BREAK ##1 st == bmp_pkg::ST_RECOVER);

endmodule // bmp_port

// file: tb/bmp_host.sv
// Purpose: Host model that drives the single-wire line of the register port
// Assumes: 50 ns clock; line pulled up when nobody pulls it low
// Notes:   Changes only at falling clock edges; every wait is bounded
`timescale 1ns/100ps
module bmp_host (
    input  wire logic clk,
    input  wire logic line,
    output logic      pull
);
    localparam int FRAME = 4000; // 200 us keeps us at the rate ceiling

    initial pull = 1'b0;

    task automatic low_for(input int n);
        pull = 1'b1;
        repeat (n) @(negedge clk);
        pull = 1'b0;
    endtask

    // Short low is a 1, long low a 0
    task automatic send_bits(input logic [7:0] b, input int n);
        int lo;
        for (int i = 0; i < n; i++) begin // LSB first
            lo = b[i] ? 300 : 2600;
            low_for(lo);
            repeat (FRAME - lo) @(negedge clk);
        end
    endtask

    task automatic send_byte(input logic [7:0] b);
        send_bits(b, 8);
    endtask

    // Break, then let recovery run out before the next command
    task automatic send_break;
        low_for(4000);
        repeat (1000) @(negedge clk);
    endtask

    task automatic recv_byte(output logic [7:0] b, output bit ok);
        int n;
        ok = 1'b1;
        for (int i = 0; i < 8; i++) begin // LSB first
            n = 0;
            while (line === 1'b1 && n < 12000) begin
                @(negedge clk);
                n++;
            end
            if (n >= 12000)
                ok = 1'b0;
            n = 0;
            while (line === 1'b0 && n < 4000) begin
                @(negedge clk);
                n++;
            end
            b[i] = (n < 1400);
        end
        repeat (FRAME) @(negedge clk);
    endtask
endmodule // bmp_host

// file: tb/bmp_port_tb.sv
// Purpose: Self-checking bench for the single-wire register port
// Assumes: Host model drives the line; open-drain wire with pull-up
// Notes:   Full-rate frames make the run long; the rate ceiling is the host's
`timescale 1ns/100ps
module bmp_port_tb;
    logic        clk;
    logic        rst;
    logic        pull;
    logic        line_out;
    logic        line_oe;
    logic [10:0] battery_voltage;
    logic [4:0]  voltage_offset;
    logic [4:0]  counter_clear;
    logic        power_down;
    logic [4:0]  clear_seen;
    logic [7:0]  d;
    wire         line_in = ~(pull | (line_oe & ~line_out));
    int          errors;
    int          total_checks;

    bmp_port i_dut (
        .clk             (clk),
        .rst             (rst),
        .line_in         (line_in),
        .line_out        (line_out),
        .line_oe         (line_oe),
        .battery_voltage (battery_voltage),
        .voltage_offset  (voltage_offset),
        .counter_clear   (counter_clear),
        .power_down      (power_down)
    );

    bmp_host i_host (
        .clk  (clk),
        .line (line_in),
        .pull (pull)
    );

    always #25 clk = ~clk;
    always @(posedge clk) clear_seen <= clear_seen | counter_clear;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        i_host.send_byte({1'b1, a});
        i_host.send_byte(v);
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        bit ok;
        i_host.send_byte({1'b0, a});
        i_host.recv_byte(v, ok);
        if (!ok) begin
            errors++;
            $display("[FAIL] answer expected 8 frames seen none");
            give_verdict();
        end
    endtask

    task automatic t_ident;
        check("idle release", {7'h00, line_oe}, 8'h00);
        rd(bmp_pkg::ADDR_ID, d);
        check("id read", d, 8'h5a);
    endtask

    task automatic t_regs;
        wr(bmp_pkg::ADDR_PROG_ADDR, 8'ha5);
        rd(bmp_pkg::ADDR_PROG_ADDR, d);
        check("program address", d, 8'ha5);
        wr(bmp_pkg::ADDR_VOLT_LOW, 8'h00);
        rd(bmp_pkg::ADDR_VOLT_LOW, d);
        check("voltage low", d, battery_voltage[7:0]);
        // Raw value only; correcting by the offset is the host's job
        rd(bmp_pkg::ADDR_VOLT_HIGH, d);
        check("voltage high", d, {voltage_offset, battery_voltage[10:8]});
    endtask

    // Erase first, then two programs must AND together
    task automatic t_program;
        wr(bmp_pkg::ADDR_FLASH_CMD, bmp_pkg::FC_ERASE1);
        wr(bmp_pkg::ADDR_PROG_DATA, 8'h3c);
        wr(bmp_pkg::ADDR_PROG_ADDR, 8'h25);
        wr(bmp_pkg::ADDR_FLASH_CMD, bmp_pkg::FC_PROGRAM);
        wr(bmp_pkg::ADDR_PROG_DATA, 8'hf0);
        wr(bmp_pkg::ADDR_FLASH_CMD, bmp_pkg::FC_PROGRAM);
        rd(7'h25, d);
        check("programmed byte", d, 8'h30);
        wr(bmp_pkg::ADDR_FLASH_CMD, bmp_pkg::FC_ERASE2);
        rd(7'h45, d);
        check("erased byte", d, 8'hff);
    endtask

    task automatic t_shadow;
        // Byte 0 so the transfer assertion sees known RAM contents
        wr(bmp_pkg::ADDR_FLASH_CMD, bmp_pkg::FC_ERASE0);
        wr(7'h00, 8'h3c);
        wr(bmp_pkg::ADDR_FLASH_CMD, bmp_pkg::FC_RAM_TO_FLASH);
        wr(7'h00, 8'h0f);
        wr(bmp_pkg::ADDR_FLASH_CMD, bmp_pkg::FC_RAM_TO_FLASH);
        wr(7'h00, 8'haa);
        wr(bmp_pkg::ADDR_FLASH_CMD, bmp_pkg::FC_FLASH_TO_RAM);
        rd(7'h00, d);
        check("shadow page", d, 8'h0c);
    endtask

    task automatic t_clear;
        clear_seen = 5'h00;
        wr(bmp_pkg::ADDR_CLEAR, 8'h18);
        check("clear pulses", {3'h0, clear_seen}, 8'h18);
        rd(bmp_pkg::ADDR_CLEAR, d);
        check("clear self reset", d, 8'h00);
    endtask

    // Abandon a command mid-byte; the next read must still work
    task automatic t_break;
        i_host.send_bits(8'h7f, 3);
        i_host.send_break();
        rd(bmp_pkg::ADDR_ID, d);
        check("read after break", d, 8'h5a);
    endtask

    task automatic t_power;
        check("awake", {7'h00, power_down}, 8'h00);
        wr(bmp_pkg::ADDR_FLASH_CMD, bmp_pkg::FC_POWER_DOWN);
        check("power down", {7'h00, power_down}, 8'h01);
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        battery_voltage = 11'h5c3;
        voltage_offset = 5'h1b;
        clear_seen = 5'h00;
        errors = 0;
        total_checks = 0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (1000) @(negedge clk);
        t_ident();
        t_regs();
        t_program();
        t_shadow();
        t_clear();
        t_break();
        t_power();
        give_verdict();
    end
endmodule // bmp_port_tb
